// *** rtl/crw_pkg.sv ***
// Contract
// - the watchdog count is six bits wide and steps up by one on every 16 Hz time base tick.
// - after system reset is released the monitor runs and counts up with no software action.
// - system reset clears the watchdog count and the one-bit key pointer to zero.
// - besides reset and an overflow, only the key pair clears the count: 0x5 written at pointer 0, then 0xA written at pointer 1.
// - every write to the service register with byte lane 0 enabled inverts the key pointer, except in the cycle of an overflow.
// - an uncleared count overflows 1.9 to 2.0 seconds after it starts and raises the watchdog irq.
// - the overflow that raises the irq also returns the key pointer to zero.
// - the watchdog irq has no mask or disable and is meant to be taken ahead of every other source.
// - the service register is a 4-bit write-only register at address 0x38 that only feeds clearing.
package crw_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int unsigned CLK_HZ      = 250_000_000;
   localparam int unsigned TICK_HZ     = 16;
   localparam int unsigned TICK_DIV    = CLK_HZ / TICK_HZ;
   localparam int unsigned DIV_W       = 24;
   localparam int unsigned OVF_TIME_MS = 2000;
   localparam int unsigned OVF_TICKS   = OVF_TIME_MS * TICK_HZ / 1000;

   ////////////////////////////////////////////////////////////////////////////
   // counter and key
   localparam int unsigned CNT_W    = 6;
   localparam logic [CNT_W-1:0] CNT_RST  = 6'h00;
   localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(OVF_TICKS - 1);
   localparam logic [CNT_W-1:0] CNT_ONE  = 6'h01;
   localparam logic             PTR_RST  = 1'b0;
   localparam int unsigned KEY_W    = 4;
   localparam logic [KEY_W-1:0] KEY_FIRST  = 4'h5;
   localparam logic [KEY_W-1:0] KEY_SECOND = 4'hA;

   ////////////////////////////////////////////////////////////////////////////
   // register map
   localparam int unsigned ADDR_W       = 8;
   localparam logic [ADDR_W-1:0] ADDR_SERVICE = 8'h38;
   localparam logic [ADDR_W-1:0] ADDR_STATUS  = 8'h3C;
   localparam int unsigned STAT_PTR_BIT = 8;
   localparam int unsigned STAT_ARM_BIT = 9;
   localparam logic [1:0]  RESP_OKAY    = 2'h0;
   localparam logic [1:0]  RESP_SLVERR  = 2'h2;
   localparam logic [31:0] WORD_ZERO    = 32'h0000_0000;

endpackage

// *** rtl/crw_tick_div.sv ***
`timescale 1ns/1ns
`default_nettype none
module crw_tick_div #(
   parameter int unsigned DIV = crw_pkg::TICK_DIV
) (
   input  wire logic clk,
   input  wire logic rst_n,
   output var  logic tick
);

   logic [crw_pkg::DIV_W-1:0] div_ff;
   logic [crw_pkg::DIV_W-1:0] nxt_div;
   logic                      tick_ff;
   logic                      nxt_tick;

   // free-running divider; the tick is one cycle wide so the count sees one edge per period
   always_comb begin
      nxt_tick = 1'b0;
      if (div_ff == crw_pkg::DIV_W'(DIV - 1)) begin
         nxt_div  = '0;
         nxt_tick = 1'b1;
      end else begin
         nxt_div = div_ff + crw_pkg::DIV_W'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         div_ff  <= '0;
         tick_ff <= 1'b0;
      end else begin
         div_ff  <= nxt_div;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;

endmodule
`default_nettype wire

// *** rtl/crw_key_seq.sv ***
`timescale 1ns/1ns
`default_nettype none
module crw_key_seq (
   input  wire logic                    clk,
   input  wire logic                    rst_n,
   input  wire logic                    wr_en,
   input  wire logic [crw_pkg::KEY_W-1:0] wr_key,
   input  wire logic                    ovf,
   output var  logic                    ptr,
   output var  logic                    armed,
   output var  logic                    clear
);

   logic ptr_ff;
   logic nxt_ptr;
   logic arm_ff;
   logic nxt_arm;

   // pointer flips on any write; overflow drops it back to zero
   always_comb begin
      nxt_ptr = ptr_ff;
      nxt_arm = arm_ff;
      if (ovf) begin
         nxt_ptr = 1'b0;
         nxt_arm = 1'b0;
      end else if (wr_en) begin
         nxt_ptr = ~ptr_ff;
         nxt_arm = !ptr_ff && (wr_key == crw_pkg::KEY_FIRST);
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ptr_ff <= crw_pkg::PTR_RST;
         arm_ff <= 1'b0;
      end else begin
         ptr_ff <= nxt_ptr;
         arm_ff <= nxt_arm;
      end
   end

   // second key only counts after a good first key, so a stray 0xA cannot clear
   assign clear = wr_en && ptr_ff && arm_ff && (wr_key == crw_pkg::KEY_SECOND);
   assign ptr   = ptr_ff;
   assign armed = arm_ff;

endmodule
`default_nettype wire

// *** rtl/crw_runaway_monitor.sv ***
// Register access over AXI4-Lite was decided locally.
`timescale 1ns/1ns
`default_nettype none
module crw_runaway_monitor #(
   parameter int unsigned TICK_DIV = crw_pkg::TICK_DIV
) (
   input  wire logic                       CLK_SYS,
   input  wire logic                       RESET_N,
   input  wire logic [crw_pkg::ADDR_W-1:0] S_AXI_AWADDR,
   input  wire logic                       S_AXI_AWVALID,
   output var  logic                       S_AXI_AWREADY,
   input  wire logic [31:0]                S_AXI_WDATA,
   input  wire logic [3:0]                 S_AXI_WSTRB,
   input  wire logic                       S_AXI_WVALID,
   output var  logic                       S_AXI_WREADY,
   output var  logic [1:0]                 S_AXI_BRESP,
   output var  logic                       S_AXI_BVALID,
   input  wire logic                       S_AXI_BREADY,
   input  wire logic [crw_pkg::ADDR_W-1:0] S_AXI_ARADDR,
   input  wire logic                       S_AXI_ARVALID,
   output var  logic                       S_AXI_ARREADY,
   output var  logic [31:0]                S_AXI_RDATA,
   output var  logic [1:0]                 S_AXI_RRESP,
   output var  logic                       S_AXI_RVALID,
   input  wire logic                       S_AXI_RREADY,
   output var  logic                       WATCHDOG_IRQ
);

   ////////////////////////////////////////////////////////////////////////////
   // declarations
   logic                       aw_held_ff;
   logic                       nxt_aw_held;
   logic [crw_pkg::ADDR_W-1:0] aw_addr_ff;
   logic [crw_pkg::ADDR_W-1:0] nxt_aw_addr;
   logic                       w_held_ff;
   logic                       nxt_w_held;
   logic [crw_pkg::KEY_W-1:0]  w_key_ff;
   logic [crw_pkg::KEY_W-1:0]  nxt_w_key;
   logic                       w_lane0_ff;
   logic                       nxt_w_lane0;
   logic                       bvalid_ff;
   logic                       nxt_bvalid;
   logic [1:0]                 bresp_ff;
   logic [1:0]                 nxt_bresp;
   logic                       rvalid_ff;
   logic                       nxt_rvalid;
   logic [1:0]                 rresp_ff;
   logic [1:0]                 nxt_rresp;
   logic [31:0]                rdata_ff;
   logic [31:0]                nxt_rdata;
   logic                       do_write;
   logic                       wr_en;
   logic [31:0]                status_word;

   logic [crw_pkg::CNT_W-1:0]  cnt_ff;
   logic [crw_pkg::CNT_W-1:0]  nxt_cnt;
   logic                       irq_ff;
   logic                       nxt_irq;
   logic                       ovf;
   logic                       tick;
   logic                       ptr;
   logic                       armed;
   logic                       clear;

   ////////////////////////////////////////////////////////////////////////////
   // sub-blocks
   crw_tick_div #(
      .DIV   (TICK_DIV)
   ) u_tick (
      .clk   (CLK_SYS),
      .rst_n (RESET_N),
      .tick  (tick)
   );

   crw_key_seq u_key (
      .clk    (CLK_SYS),
      .rst_n  (RESET_N),
      .wr_en  (wr_en),
      .wr_key (w_key_ff),
      .ovf    (ovf),
      .ptr    (ptr),
      .armed  (armed),
      .clear  (clear)
   );

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite write path: address and data are caught independently
   assign S_AXI_AWREADY = !aw_held_ff && !bvalid_ff;
   assign S_AXI_WREADY  = !w_held_ff && !bvalid_ff;
   assign do_write      = aw_held_ff && w_held_ff && !bvalid_ff;
   // byte lane 0 carries the 4-bit key; a write without it does not touch the block
   assign wr_en = do_write && (aw_addr_ff == crw_pkg::ADDR_SERVICE) && w_lane0_ff;

   always_comb begin
      nxt_aw_held = aw_held_ff;
      nxt_aw_addr = aw_addr_ff;
      nxt_w_held  = w_held_ff;
      nxt_w_key   = w_key_ff;
      nxt_w_lane0 = w_lane0_ff;
      nxt_bvalid  = bvalid_ff;
      nxt_bresp   = bresp_ff;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
         nxt_aw_held = 1'b1;
         nxt_aw_addr = S_AXI_AWADDR;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
         nxt_w_held  = 1'b1;
         nxt_w_key   = S_AXI_WDATA[crw_pkg::KEY_W-1:0];
         nxt_w_lane0 = S_AXI_WSTRB[0];
      end
      if (do_write) begin
         nxt_aw_held = 1'b0;
         nxt_w_held  = 1'b0;
         nxt_bvalid  = 1'b1;
         // status writes are ignored quietly; only unmapped addresses fail
         if (aw_addr_ff == crw_pkg::ADDR_SERVICE || aw_addr_ff == crw_pkg::ADDR_STATUS) begin
            nxt_bresp = crw_pkg::RESP_OKAY;
         end else begin
            nxt_bresp = crw_pkg::RESP_SLVERR;
         end
      end else if (bvalid_ff && S_AXI_BREADY) begin
         nxt_bvalid = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         aw_held_ff <= 1'b0;
         aw_addr_ff <= '0;
         w_held_ff  <= 1'b0;
         w_key_ff   <= '0;
         w_lane0_ff <= 1'b0;
         bvalid_ff  <= 1'b0;
         bresp_ff   <= crw_pkg::RESP_OKAY;
      end else begin
         aw_held_ff <= nxt_aw_held;
         aw_addr_ff <= nxt_aw_addr;
         w_held_ff  <= nxt_w_held;
         w_key_ff   <= nxt_w_key;
         w_lane0_ff <= nxt_w_lane0;
         bvalid_ff  <= nxt_bvalid;
         bresp_ff   <= nxt_bresp;
      end
   end

   assign S_AXI_BVALID = bvalid_ff;
   assign S_AXI_BRESP  = bresp_ff;

   ////////////////////////////////////////////////////////////////////////////
   // axi4-lite read path: one read at a time, answer one cycle after the address
   assign S_AXI_ARREADY = !rvalid_ff;

   // status word: count, pointer and first-key flag for debug visibility
   always_comb begin
      status_word                        = crw_pkg::WORD_ZERO;
      status_word[crw_pkg::CNT_W-1:0]    = cnt_ff;
      status_word[crw_pkg::STAT_PTR_BIT] = ptr;
      status_word[crw_pkg::STAT_ARM_BIT] = armed;
   end

   always_comb begin
      nxt_rvalid = rvalid_ff;
      nxt_rdata  = rdata_ff;
      nxt_rresp  = rresp_ff;
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
         nxt_rvalid = 1'b1;
         nxt_rresp  = crw_pkg::RESP_OKAY;
         nxt_rdata  = crw_pkg::WORD_ZERO;
         if (S_AXI_ARADDR == crw_pkg::ADDR_STATUS) begin
            nxt_rdata = status_word;
         end else if (S_AXI_ARADDR != crw_pkg::ADDR_SERVICE) begin
            nxt_rresp = crw_pkg::RESP_SLVERR;
         end
         // the service register is write-only and reads back as zero
      end else if (rvalid_ff && S_AXI_RREADY) begin
         nxt_rvalid = 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         rvalid_ff <= 1'b0;
         rdata_ff  <= crw_pkg::WORD_ZERO;
         rresp_ff  <= crw_pkg::RESP_OKAY;
      end else begin
         rvalid_ff <= nxt_rvalid;
         rdata_ff  <= nxt_rdata;
         rresp_ff  <= nxt_rresp;
      end
   end

   assign S_AXI_RVALID = rvalid_ff;
   assign S_AXI_RDATA  = rdata_ff;
   assign S_AXI_RRESP  = rresp_ff;

   ////////////////////////////////////////////////////////////////////////////
   // watchdog count; a key clear in the tick cycle wins so a timely service is never lost
   assign ovf = tick && !clear && (cnt_ff == crw_pkg::CNT_LAST);

   always_comb begin
      nxt_cnt = cnt_ff;
      nxt_irq = ovf;                                     // no mask on purpose
      if (clear) begin
         nxt_cnt = crw_pkg::CNT_RST;
      end else if (ovf) begin
         nxt_cnt = crw_pkg::CNT_RST;
      end else if (tick) begin
         nxt_cnt = cnt_ff + crw_pkg::CNT_ONE;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
         cnt_ff <= crw_pkg::CNT_RST;
         irq_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         irq_ff <= nxt_irq;
      end
   end

   assign WATCHDOG_IRQ = irq_ff;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   sequence seq_quiet_tick;
      tick && !clear;
   endsequence

   // a stray write between the keys inverts the pointer, so only adjacent writes pair up
   sequence seq_first_key;
      wr_en && !ptr && (w_key_ff == crw_pkg::KEY_FIRST) && !ovf;
   endsequence

   sequence seq_second_key;
      wr_en && ptr && armed && (w_key_ff == crw_pkg::KEY_SECOND);
   endsequence

   chk_reset_clears: assert property (@(posedge CLK_SYS)
      !RESET_N |=> (cnt_ff == crw_pkg::CNT_RST) && !ptr && !WATCHDOG_IRQ)
      else $error("reset did not clear count and pointer");

   chk_tick_step: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      seq_quiet_tick ##0 (cnt_ff != crw_pkg::CNT_LAST)
      |=> cnt_ff == $past(cnt_ff) + crw_pkg::CNT_ONE)
      else $error("count did not step on tick");

   chk_runs_alone: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      !tick && !clear |=> cnt_ff == $past(cnt_ff))
      else $error("count moved without a tick");

   chk_key_clears: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      seq_second_key |=> cnt_ff == crw_pkg::CNT_RST)
      else $error("key pair did not clear count");

   chk_ptr_flips: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      wr_en && !ovf |=> ptr != $past(ptr))
      else $error("write did not invert pointer");

   chk_ovf_irq: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      seq_quiet_tick ##0 (cnt_ff == crw_pkg::CNT_LAST) |=> WATCHDOG_IRQ ##1 !WATCHDOG_IRQ)
      else $error("overflow did not give one irq pulse");

   chk_ovf_ptr: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      ovf |=> !ptr && (cnt_ff == crw_pkg::CNT_RST))
      else $error("overflow did not zero pointer");

   chk_irq_cause: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      WATCHDOG_IRQ |-> $past(tick) && ($past(cnt_ff) == crw_pkg::CNT_LAST))
      else $error("irq without overflow");

   chk_service_wo: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      S_AXI_ARVALID && S_AXI_ARREADY && (S_AXI_ARADDR == crw_pkg::ADDR_SERVICE)
      |=> S_AXI_RVALID && (S_AXI_RDATA == crw_pkg::WORD_ZERO))
      else $error("service register read back non-zero");

   chk_bad_key: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      wr_en && !clear && !tick |=> cnt_ff == $past(cnt_ff))
      else $error("wrong key changed the count");

   chk_first_arms: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      seq_first_key |=> armed && ptr)
      else $error("first key did not arm the pair");

   chk_tick_single: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      tick |=> !tick)
      else $error("tick wider than one cycle");

   // bus answers must stand until taken, or the master may read a moving value
   chk_b_holds: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
      else $error("write response dropped or changed");

   chk_r_holds: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      S_AXI_RVALID && !S_AXI_RREADY
      |=> S_AXI_RVALID && $stable(S_AXI_RDATA) && $stable(S_AXI_RRESP))
      else $error("read response dropped or changed");

   chk_write_answers: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      do_write |=> S_AXI_BVALID)
      else $error("write got no response");

   chk_lane_gate: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
      do_write && (aw_addr_ff == crw_pkg::ADDR_SERVICE) && !w_lane0_ff && !ovf
      |=> ptr == $past(ptr))
      else $error("write without lane 0 moved the pointer");

endmodule
`default_nettype wire

// *** sim/crw_runaway_monitor_test.sv ***
`timescale 1ns/1ns
`default_nettype none
module crw_runaway_monitor_test;
   // short divider so an overflow period is 32 * DIV cycles
   localparam int unsigned DIV   = 4;
   localparam int unsigned LIMIT = 6000;

   logic        clk_sys;
   logic        reset_n;
   logic [7:0]  awaddr;
   logic        awvalid;
   logic        aw_ready;
   logic [31:0] wdata;
   logic [3:0]  wstrb;
   logic        wvalid;
   logic        w_ready;
   logic [1:0]  bresp;
   logic        bvalid;
   logic        bready;
   logic [7:0]  araddr;
   logic        arvalid;
   logic        ar_ready;
   logic [31:0] rdata;
   logic [1:0]  rresp;
   logic        rvalid;
   logic        rready;
   logic        irq;
   logic [31:0] st;
   logic [31:0] st2;
   logic [31:0] rd;
   logic [1:0]  br;
   logic [1:0]  rr;
   int          failures;
   int          num_checks;
   int          cyc;
   int          t0;
   int          n;
   int          irq_cnt;

   crw_runaway_monitor #(.TICK_DIV(DIV)) u_crw_runaway_monitor (
      .CLK_SYS       (clk_sys),
      .RESET_N       (reset_n),
      .S_AXI_AWADDR  (awaddr),
      .S_AXI_AWVALID (awvalid),
      .S_AXI_AWREADY (aw_ready),
      .S_AXI_WDATA   (wdata),
      .S_AXI_WSTRB   (wstrb),
      .S_AXI_WVALID  (wvalid),
      .S_AXI_WREADY  (w_ready),
      .S_AXI_BRESP   (bresp),
      .S_AXI_BVALID  (bvalid),
      .S_AXI_BREADY  (bready),
      .S_AXI_ARADDR  (araddr),
      .S_AXI_ARVALID (arvalid),
      .S_AXI_ARREADY (ar_ready),
      .S_AXI_RDATA   (rdata),
      .S_AXI_RRESP   (rresp),
      .S_AXI_RVALID  (rvalid),
      .S_AXI_RREADY  (rready),
      .WATCHDOG_IRQ  (irq)
   );

   ////////////////////////////////////////////////////////////////////////////
   // clock, cycle count with hang guard, irq pulse count
   always #2 clk_sys = ~clk_sys;

   always @(posedge clk_sys) begin
      cyc++;
      if (irq === 1'b1) irq_cnt++;
      if (cyc >= LIMIT) begin
         failures++;
         finish_test();
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus tasks; readies are looked at 1 ns after an edge, once settled
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      logic aw_d;
      logic w_d;
      logic aw_hit;
      logic w_hit;
      logic b_hit;
      aw_d = 1'b0;
      w_d  = 1'b0;
      @(posedge clk_sys);
      awaddr  <= a;
      awvalid <= 1'b1;
      wdata   <= d;
      wstrb   <= s;
      wvalid  <= 1'b1;
      // each half is dropped on the edge that took it
      while (!(aw_d && w_d)) begin
         #1;
         aw_hit = !aw_d && aw_ready;
         w_hit  = !w_d && w_ready;
         @(posedge clk_sys);
         if (aw_hit) begin
            awvalid <= 1'b0;
            aw_d = 1'b1;
         end
         if (w_hit) begin
            wvalid <= 1'b0;
            w_d = 1'b1;
         end
      end
      bready <= 1'b1;
      b_hit = 1'b0;
      while (!b_hit) begin
         #1;
         b_hit = bvalid;
         br    = bresp;
         @(posedge clk_sys);
      end
      bready <= 1'b0;
   endtask

   task automatic axi_read(input logic [7:0] a);
      logic hit;
      @(posedge clk_sys);
      araddr  <= a;
      arvalid <= 1'b1;
      hit = 1'b0;
      while (!hit) begin
         #1;
         hit = ar_ready;
         @(posedge clk_sys);
      end
      arvalid <= 1'b0;
      rready  <= 1'b1;
      hit = 1'b0;
      while (!hit) begin
         #1;
         hit = rvalid;
         rd  = rdata;
         rr  = rresp;
         @(posedge clk_sys);
      end
      rready <= 1'b0;
   endtask

   task automatic svc(input logic [3:0] key);
      axi_write(crw_pkg::ADDR_SERVICE, {28'h0000000, key}, 4'hF);
   endtask

   task automatic rd_stat(output logic [31:0] v);
      axi_read(crw_pkg::ADDR_STATUS);
      v = rd;
   endtask

   task automatic finish_test;
      if (failures == 0 && num_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      clk_sys = 1'b0;
      reset_n = 1'b0;
      {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
      {araddr, arvalid, rready} = '0;
      {failures, num_checks, cyc, irq_cnt} = '0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1'b1;
      rd_stat(st);
      chk("ptr_after_reset", 32'h0, {31'h0, st[8]});
      chk("count_after_reset", 32'h1, {31'h0, st[5:0] <= 6'h01});
      axi_read(crw_pkg::ADDR_SERVICE);
      chk("service_rdata", 32'h0, rd);
      chk("service_rresp", {30'h0, crw_pkg::RESP_OKAY}, {30'h0, rr});
      // free running count: the read task adds three cycles, so address edges are 8 ticks apart
      rd_stat(st);
      repeat (8 * DIV - 3) @(posedge clk_sys);
      rd_stat(st2);
      chk("count_step", 32'h8, {26'h0, st2[5:0] - st[5:0]});
      svc(crw_pkg::KEY_FIRST);
      rd_stat(st);
      chk("ptr_first_key", 32'h1, {31'h0, st[8]});
      chk("arm_first_key", 32'h1, {31'h0, st[9]});
      svc(crw_pkg::KEY_SECOND);
      rd_stat(st);
      chk("ptr_second_key", 32'h0, {31'h0, st[8]});
      chk("count_cleared", 32'h1, {31'h0, st[5:0] <= 6'h01});
      repeat (10 * DIV) @(posedge clk_sys);
      rd_stat(st2);
      // lane 0 off: the write is accepted but must not act
      axi_write(crw_pkg::ADDR_SERVICE, 32'h0000_0005, 4'hE);
      chk("nolane_bresp", {30'h0, crw_pkg::RESP_OKAY}, {30'h0, br});
      svc(4'h3);
      rd_stat(st);
      chk("ptr_wrong_key", 32'h1, {31'h0, st[8]});
      chk("arm_wrong_key", 32'h0, {31'h0, st[9]});
      chk("count_kept_wrong", 32'h1, {31'h0, st[5:0] >= st2[5:0]});
      // second key without an accepted first key leaves the count alone
      svc(crw_pkg::KEY_SECOND);
      rd_stat(st);
      chk("ptr_lone_second", 32'h0, {31'h0, st[8]});
      chk("count_kept_lone", 32'h1, {31'h0, st[5:0] >= st2[5:0]});
      chk("no_irq_yet", 32'h0, irq_cnt);
      // overflow: clear, leave pointer at 1, try to silence it via status
      svc(crw_pkg::KEY_FIRST);
      svc(crw_pkg::KEY_SECOND);
      t0 = cyc;
      svc(crw_pkg::KEY_FIRST);
      axi_write(crw_pkg::ADDR_STATUS, 32'hFFFF_FFFF, 4'hF);
      chk("status_wr_bresp", {30'h0, crw_pkg::RESP_OKAY}, {30'h0, br});
      n = 0;
      while (irq !== 1'b1 && n < 300) begin
         @(posedge clk_sys);
         #1;
         n++;
      end
      chk("ovf_delay", 32'h1, {31'h0, (cyc - t0 >= 31 * DIV - 3) && (cyc - t0 <= 32 * DIV + 2)});
      @(posedge clk_sys);
      #1;
      chk("irq_pulse_end", 32'h0, {31'h0, irq});
      rd_stat(st);
      chk("ptr_after_ovf", 32'h0, {31'h0, st[8]});
      chk("count_wrapped", 32'h1, {31'h0, st[5:0] <= 6'h01});
      chk("irq_once", 32'h1, irq_cnt);
      // regular servicing well inside the period keeps it quiet
      repeat (4) begin
         svc(crw_pkg::KEY_FIRST);
         svc(crw_pkg::KEY_SECOND);
         repeat (20 * DIV) @(posedge clk_sys);
      end
      chk("serviced_no_irq", 32'h1, irq_cnt);
      // unmapped and misaligned places
      axi_write(8'h40, 32'h0000_000A, 4'hF);
      chk("unmapped_bresp", {30'h0, crw_pkg::RESP_SLVERR}, {30'h0, br});
      axi_read(8'h40);
      chk("unmapped_rdata", 32'h0, rd);
      chk("unmapped_rresp", {30'h0, crw_pkg::RESP_SLVERR}, {30'h0, rr});
      axi_read(8'h39);
      chk("misaligned_rresp", {30'h0, crw_pkg::RESP_SLVERR}, {30'h0, rr});
      finish_test();
   end
endmodule
`default_nettype wire
